// >>> src/dlw_core.sv
// defect data response formatter and buffer write command executor
// assumes a combinational defect store lookup and a byte-wide buffer port
`include "dlw_map.svh"
`timescale 1ns/10ps
`default_nettype none
module dlw_core #(
  parameter logic [23:0] SEG_CAP = `DLW_BUF_CAP // selected segment size
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command block in
  input wire logic cdb_valid,
  input wire dlw_pkg::dlw_cdb_type cdb,
  input wire logic [2:0] issuer_id,
  output logic cdb_ready,
  // defect store lookup
  input wire logic [13:0] factory_count,
  input wire logic [13:0] grown_count,
  output logic [13:0] desc_index,
  output logic desc_grown,
  input wire dlw_pkg::dlw_defect_type desc_entry,
  // data-in byte stream to the initiator
  output logic din_valid,
  output logic [7:0] din_data,
  input wire logic din_ready,
  // data-out byte stream from the initiator
  input wire logic dout_valid,
  input wire logic [7:0] dout_data,
  output logic dout_ready,
  output logic dout_phase,
  // buffer and non-volatile store
  output dlw_pkg::dlw_bufwr_type buf_wr,
  output logic nv_commit,
  // attention and completion
  output logic ua_post,
  output logic [7:0] ua_mask,
  output logic [7:0] ua_asc,
  output logic cmd_done,
  output dlw_pkg::dlw_status_type status
);

  // mode decode, shared by acceptance and checks
  function automatic dlw_pkg::dlw_mode_type mode_of(input logic [2:0] m);
    case (m)
      `DLW_MODE_COMBINED: mode_of = dlw_pkg::dlw_mode_combined;
      `DLW_MODE_DATA: mode_of = dlw_pkg::dlw_mode_data;
      `DLW_MODE_DLSAVE: mode_of = dlw_pkg::dlw_mode_dlsave;
      default: mode_of = dlw_pkg::dlw_mode_bad;
    endcase
  endfunction

  // three-byte big-endian field from the command block
  function automatic logic [23:0] field3(input dlw_pkg::dlw_cdb_type c,
                                         input int b);
    field3 = {c[b], c[b + 1], c[b + 2]};
  endfunction

  // state registers
  dlw_pkg::dlw_state_type state, next_state;
  dlw_pkg::dlw_mode_type mode, next_mode; // mode of the running write
  logic ok, next_ok; // write data may land in the buffer
  logic is_write, next_is_write; // running command is a buffer write
  logic [23:0] rem, next_rem; // data-out bytes still owed
  logic [2:0] skip, next_skip; // header bytes still to drop
  logic [23:0] addr, next_addr; // next buffer location
  logic [7:0] seg, next_seg; // selected segment
  logic [23:0] idx, next_idx; // next data-in byte number
  logic [23:0] send_len, next_send_len; // data-in byte count
  logic [23:0] list_len, next_list_len; // descriptor bytes in the list
  logic incl_f, next_incl_f; // factory list requested
  logic incl_g, next_incl_g; // grown list requested
  logic [2:0] fmt, next_fmt; // format actually sent
  logic [2:0] who, next_who; // issuer of the command
  logic next_din_valid;
  logic [7:0] next_din_data;
  dlw_pkg::dlw_bufwr_type next_buf_wr;
  logic next_nv_commit, next_ua_post, next_cmd_done;
  logic [7:0] next_ua_mask;
  dlw_pkg::dlw_status_type next_status;

  // combinational helpers
  logic [23:0] len_f, ofs_f, alloc_f, total_f, rel;
  logic [13:0] nf, ng;
  logic [20:0] dnum;
  logic [31:0] tail;
  logic [7:0] dbyte;

  assign cdb_ready = (state == dlw_pkg::dlw_idle);
  // only the owed bytes are taken; an error leaves nothing owed
  assign dout_ready = (state == dlw_pkg::dlw_dout) && ok && (rem != 24'h000000);
  assign dout_phase = (state == dlw_pkg::dlw_dout);
  assign ua_asc = `DLW_ASC_COND_CHANGED;

  // descriptor lookup: factory entries precede grown entries
  always_comb begin
    rel = idx - `DLW_HDR_LEN;
    dnum = rel[23:3];
    nf = incl_f ? factory_count : 14'h0000;
    desc_grown = !(incl_f && (dnum < {7'h00, factory_count}));
    desc_index = desc_grown ? (dnum[13:0] - nf) : dnum[13:0];
    // one format chosen per response, never mixed
    tail = (fmt == `DLW_FMT_INDEX) ? desc_entry.bytes_ofs : desc_entry.sector;
    case (rel[2:0])
      3'h0: dbyte = desc_entry.cyl[23:16];
      3'h1: dbyte = desc_entry.cyl[15:8];
      3'h2: dbyte = desc_entry.cyl[7:0];
      3'h3: dbyte = desc_entry.head;
      3'h4: dbyte = tail[31:24];
      3'h5: dbyte = tail[23:16];
      3'h6: dbyte = tail[15:8];
      default: dbyte = tail[7:0];
    endcase
  end

  // next state of the whole command engine
  always_comb begin
    len_f = field3(cdb, `DLW_CDB_LEN);
    ofs_f = field3(cdb, `DLW_CDB_OFS);
    alloc_f = {8'h00, cdb[`DLW_CDB_ALLOC], cdb[`DLW_CDB_ALLOC + 1]};
    ng = cdb[`DLW_CDB_FLAGS][`DLW_GROWN_BIT] ? grown_count : 14'h0000;
    total_f = {7'h00, (cdb[`DLW_CDB_FLAGS][`DLW_FACTORY_BIT] ? factory_count : 14'h0000)
               + ng, 3'b000};
    next_state = state;
    next_mode = mode;
    next_ok = ok;
    next_is_write = is_write;
    next_rem = rem;
    next_skip = skip;
    next_addr = addr;
    next_seg = seg;
    next_idx = idx;
    next_send_len = send_len;
    next_list_len = list_len;
    next_incl_f = incl_f;
    next_incl_g = incl_g;
    next_fmt = fmt;
    next_who = who;
    next_din_valid = din_valid;
    next_din_data = din_data;
    next_buf_wr = buf_wr;
    next_buf_wr.we = 1'b0;
    next_nv_commit = 1'b0;
    next_ua_post = 1'b0;
    next_ua_mask = ua_mask;
    next_cmd_done = 1'b0;
    next_status = status;
    case (state)
      dlw_pkg::dlw_idle: begin
        if (cdb_valid) begin
          next_who = issuer_id;
          next_status = '0;
          if (cdb[`DLW_CDB_OP] == `DLW_OP_WRBUF) begin
            next_is_write = 1'b1;
            next_mode = mode_of(cdb[`DLW_CDB_MODE][2:0]);
            next_state = dlw_pkg::dlw_dout;
            next_rem = len_f;
            next_ok = 1'b1;
            next_skip = 3'h0;
            next_addr = 24'h000000;
            next_seg = 8'h00;
            case (mode_of(cdb[`DLW_CDB_MODE][2:0]))
              dlw_pkg::dlw_mode_combined: begin
                next_skip = `DLW_HDR_SKIP;
                if (len_f > SEG_CAP + `DLW_HDR_LEN) begin
                  next_ok = 1'b0;
                end
              end
              dlw_pkg::dlw_mode_data: begin
                next_addr = ofs_f;
                next_seg = cdb[`DLW_CDB_ID];
                if ({1'b0, ofs_f} + {1'b0, len_f} > {1'b0, SEG_CAP}) begin
                  next_ok = 1'b0;
                end
              end
              // id and offset are not looked at here
              dlw_pkg::dlw_mode_dlsave: next_addr = 24'h000000;
              default: next_ok = 1'b0;
            endcase
          end else if (cdb[`DLW_CDB_OP] == `DLW_OP_RDDEF) begin
            next_is_write = 1'b0;
            next_state = dlw_pkg::dlw_din;
            next_incl_f = cdb[`DLW_CDB_FLAGS][`DLW_FACTORY_BIT];
            next_incl_g = cdb[`DLW_CDB_FLAGS][`DLW_GROWN_BIT];
            next_list_len = total_f;
            next_idx = 24'h000000;
            // full length is reported, but only the smaller amount is sent
            next_send_len = (alloc_f < total_f + `DLW_HDR_LEN) ? alloc_f
                            : total_f + `DLW_HDR_LEN;
            if (cdb[`DLW_CDB_FLAGS][2:0] == `DLW_FMT_INDEX) begin
              next_fmt = `DLW_FMT_INDEX;
            end else begin
              next_fmt = `DLW_FMT_SECTOR;
              if (cdb[`DLW_CDB_FLAGS][2:0] != `DLW_FMT_SECTOR) begin
                next_status = '{1'b1, `DLW_SK_RECOVERED, `DLW_ASC_FMT_NA};
              end
            end
          end else begin
            // unknown opcode: answer at once with illegal request
            next_status = '{1'b1, `DLW_SK_ILLEGAL, `DLW_ASC_INV_FIELD};
            next_cmd_done = 1'b1;
          end
        end
      end
      dlw_pkg::dlw_dout: begin
        if (!ok) begin
          // the phase is entered, but an illegal command takes no bytes
          next_rem = 24'h000000;
          next_state = dlw_pkg::dlw_done;
        end else if (rem == 24'h000000) begin
          next_state = dlw_pkg::dlw_done;
        end else if (dout_valid) begin
          next_rem = rem - 24'h000001;
          if (skip != 3'h0) begin
            next_skip = skip - 3'h1;
          end else begin
            next_buf_wr = '{1'b1, mode == dlw_pkg::dlw_mode_dlsave, seg, addr,
                            dout_data};
            next_addr = addr + 24'h000001;
          end
        end
      end
      dlw_pkg::dlw_din: begin
        if (!din_valid || din_ready) begin
          if (idx < send_len) begin
            next_din_valid = 1'b1;
            next_idx = idx + 24'h000001;
            case (idx)
              24'h000000: next_din_data = 8'h00;
              24'h000001: next_din_data = {3'b000, incl_f, incl_g, fmt};
              24'h000002: next_din_data = list_len[15:8];
              24'h000003: next_din_data = list_len[7:0];
              default: next_din_data = dbyte;
            endcase
          end else begin
            next_din_valid = 1'b0;
            next_state = dlw_pkg::dlw_done;
          end
        end
      end
      dlw_pkg::dlw_done: begin
        next_state = dlw_pkg::dlw_idle;
        next_cmd_done = 1'b1;
        if (is_write) begin
          if (!ok) begin
            next_status = '{1'b1, `DLW_SK_ILLEGAL, `DLW_ASC_INV_FIELD};
          end else if (mode == dlw_pkg::dlw_mode_dlsave) begin
            next_nv_commit = 1'b1;
            next_ua_post = 1'b1;
            next_ua_mask = ~(8'h01 << who);
          end
        end
      end
      default: next_state = dlw_pkg::dlw_idle;
    endcase
  end

  // register every piece of state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= dlw_pkg::dlw_idle;
      mode <= dlw_pkg::dlw_mode_bad;
      ok <= 1'b0;
      is_write <= 1'b0;
      rem <= 24'h000000;
      skip <= 3'h0;
      addr <= 24'h000000;
      seg <= 8'h00;
      idx <= 24'h000000;
      send_len <= 24'h000000;
      list_len <= 24'h000000;
      incl_f <= 1'b0;
      incl_g <= 1'b0;
      fmt <= `DLW_FMT_SECTOR;
      who <= 3'h0;
      din_valid <= 1'b0;
      din_data <= 8'h00;
      buf_wr <= '0;
      nv_commit <= 1'b0;
      ua_post <= 1'b0;
      ua_mask <= 8'h00;
      cmd_done <= 1'b0;
      status <= '0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      ok <= next_ok;
      is_write <= next_is_write;
      rem <= next_rem;
      skip <= next_skip;
      addr <= next_addr;
      seg <= next_seg;
      idx <= next_idx;
      send_len <= next_send_len;
      list_len <= next_list_len;
      incl_f <= next_incl_f;
      incl_g <= next_incl_g;
      fmt <= next_fmt;
      who <= next_who;
      din_valid <= next_din_valid;
      din_data <= next_din_data;
      buf_wr <= next_buf_wr;
      nv_commit <= next_nv_commit;
      ua_post <= next_ua_post;
      ua_mask <= next_ua_mask;
      cmd_done <= next_cmd_done;
      status <= next_status;
    end
  end

endmodule
`default_nettype wire

// >>> src/dlw_map.svh
// named constants for the defect list and buffer write command handler
// assumes it is included by bare name from the module and the testbench files
`ifndef DLW_MAP_SVH
`define DLW_MAP_SVH
// operation codes
`define DLW_OP_WRBUF 8'h3b
`define DLW_OP_RDDEF 8'h37
// command block byte positions
`define DLW_CDB_OP 0
`define DLW_CDB_MODE 1
`define DLW_CDB_ID 2
`define DLW_CDB_OFS 3
`define DLW_CDB_LEN 6
`define DLW_CDB_FLAGS 2
`define DLW_CDB_ALLOC 7
// bit positions in the flag bytes
`define DLW_FACTORY_BIT 4
`define DLW_GROWN_BIT 3
// buffer write mode codes
`define DLW_MODE_COMBINED 3'b000
`define DLW_MODE_DATA 3'b010
`define DLW_MODE_DLSAVE 3'b101
// defect list format codes
`define DLW_FMT_SECTOR 3'b101
`define DLW_FMT_INDEX 3'b100
// lengths in bytes
`define DLW_HDR_LEN 24'h000004
`define DLW_HDR_SKIP 3'h4
`define DLW_BUF_CAP 24'h060000
// sense values, arbitrary plain defaults
`define DLW_SK_NONE 4'h0
`define DLW_SK_RECOVERED 4'h1
`define DLW_SK_ILLEGAL 4'h5
`define DLW_ASC_NONE 8'h00
`define DLW_ASC_INV_FIELD 8'h24
`define DLW_ASC_FMT_NA 8'h1c
`define DLW_ASC_COND_CHANGED 8'h3f
`endif

// >>> src/dlw_pkg.sv
// types shared by the defect list and buffer write handler
// assumes dlw_map.svh is on the include path
package dlw_pkg;
  // ten byte command block, byte 0 first
  typedef logic [0:9][7:0] dlw_cdb_type;
  // one defect location as the media store holds it
  typedef struct packed {
    logic [23:0] cyl;
    logic [7:0] head;
    logic [31:0] sector;
    logic [31:0] bytes_ofs;
  } dlw_defect_type;
  // one buffer byte write
  typedef struct packed {
    logic we;
    logic code;
    logic [7:0] seg;
    logic [23:0] addr;
    logic [7:0] data;
  } dlw_bufwr_type;
  // completion status
  typedef struct packed {
    logic check;
    logic [3:0] key;
    logic [7:0] asc;
  } dlw_status_type;
  typedef enum logic [2:0] {
    dlw_mode_combined,
    dlw_mode_data,
    dlw_mode_dlsave,
    dlw_mode_bad
  } dlw_mode_type;
  typedef enum logic [1:0] {
    dlw_idle,
    dlw_dout,
    dlw_din,
    dlw_done
  } dlw_state_type;
endpackage

// >>> testbench/dlw_core_assertions.sv
// concurrent checks for the defect list and buffer write handler
// assumes binding to dlw_core and sight of its ports only
`include "dlw_map.svh"
`timescale 1ns/10ps
`default_nettype none
module dlw_core_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command side
  input wire logic cdb_valid,
  input wire logic cdb_ready,
  input wire dlw_pkg::dlw_cdb_type cdb,
  // streams
  input wire logic din_valid,
  input wire logic [7:0] din_data,
  input wire logic din_ready,
  input wire logic dout_valid,
  input wire logic dout_ready,
  input wire logic dout_phase,
  // results
  input wire dlw_pkg::dlw_bufwr_type buf_wr,
  input wire logic nv_commit,
  input wire logic ua_post,
  input wire logic [7:0] ua_mask,
  input wire logic [7:0] ua_asc,
  input wire logic cmd_done,
  input wire dlw_pkg::dlw_status_type status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // header bytes still to be dropped by a running combined write
  logic [2:0] hdr_left;
  // only ports are visible, so the header count is rebuilt from the taken bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hdr_left <= 3'h0;
    end else if (cdb_valid && cdb_ready) begin
      hdr_left <= (cdb[0] == `DLW_OP_WRBUF && cdb[1][2:0] == `DLW_MODE_COMBINED) ?
                  `DLW_HDR_SKIP : 3'h0;
    end else if (dout_valid && dout_ready && hdr_left != 3'h0) begin
      hdr_left <= hdr_left - 3'h1;
    end
  end
  // write command taken with a mode code that is not served
  sequence s_bad_take;
    cdb_valid && cdb_ready && cdb[0] == 8'h3b &&
      cdb[1][2:0] inside {3'h1, 3'h3, 3'h4, 3'h6, 3'h7};
  endsequence
  // one empty data-out cycle, then the error completion
  sequence s_refuse;
    dout_phase && !dout_ready ##1 !dout_phase ##[1:2]
      cmd_done && status.check && status.key == `DLW_SK_ILLEGAL;
  endsequence
  // defect read taken with room for at least one byte
  sequence s_rd_take;
    cdb_valid && cdb_ready && cdb[0] == 8'h37 && (cdb[7] | cdb[8]) != 8'h00;
  endsequence
  a_bad_refused: assert property (s_bad_take |=> s_refuse)
    else $error("bad mode not refused");
  a_bad_no_write: assert property (s_bad_take |=> !buf_wr.we [*4])
    else $error("bad mode stored a byte");
  a_byte_stored: assert property (dout_valid && dout_ready && hdr_left == 3'h0 |=> buf_wr.we)
    else $error("taken byte not stored");
  a_hdr_dropped: assert property (dout_valid && dout_ready && hdr_left != 3'h0 |=> !buf_wr.we)
    else $error("header byte stored");
  a_store_cause: assert property (buf_wr.we |-> $past(dout_valid && dout_ready))
    else $error("store without a taken byte");
  a_ready_phase: assert property (dout_ready |-> dout_phase)
    else $error("byte taken outside data-out");
  a_commit_ok: assert property (nv_commit |-> cmd_done && !status.check)
    else $error("commit without good completion");
  a_attn_code: assert property (ua_post |-> nv_commit &&
    ua_asc == `DLW_ASC_COND_CHANGED && $countones(ua_mask) == 7)
    else $error("attention post malformed");
  a_din_hold: assert property (din_valid && !din_ready |=>
    din_valid && $stable(din_data))
    else $error("data-in byte dropped");
  a_defect_lead: assert property (s_rd_take |-> ##[1:2] din_valid && din_data == 8'h00)
    else $error("defect header byte wrong");
endmodule
bind dlw_core dlw_core_chk chk (.clk(clk), .rst(rst), .cdb_valid(cdb_valid),
  .cdb_ready(cdb_ready), .cdb(cdb), .din_valid(din_valid), .din_data(din_data),
  .din_ready(din_ready), .dout_valid(dout_valid), .dout_ready(dout_ready),
  .dout_phase(dout_phase), .buf_wr(buf_wr), .nv_commit(nv_commit), .ua_post(ua_post),
  .ua_mask(ua_mask), .ua_asc(ua_asc), .cmd_done(cmd_done), .status(status));
`default_nettype wire

// >>> testbench/dlw_host.sv
// initiator model: feeds data-out bytes and gathers data-in bytes
// assumes the bench sets go for the length of one command
`timescale 1ns/10ps
`default_nettype none
module dlw_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic go,
  input wire logic stall,
  input wire logic [23:0] count,
  // data-out stream to the target
  output logic dout_valid,
  output logic [7:0] dout_data,
  input wire logic dout_ready,
  // data-in stream from the target
  input wire logic din_valid,
  input wire logic [7:0] din_data,
  output logic din_ready
);
  logic [23:0] sent = 24'h0; // bytes taken so far
  logic took = 1'b0; // a byte went at the last rising edge
  logic [7:0] rx[$]; // data-in bytes received
  initial begin
    dout_valid = 1'b0;
    dout_data = 8'h5a;
    din_ready = 1'b0;
  end
  // bookkeeping on the sampling edge
  always @(posedge clk) begin
    took <= dout_valid && dout_ready;
    if (rst || !go) begin
      sent <= 24'h0;
    end else if (dout_valid && dout_ready) begin
      sent <= sent + 24'h1;
    end
    if (din_valid && din_ready) begin
      rx.push_back(din_data);
    end
  end
  // an offer is held until taken; idle data keeps changing so it is never trusted
  always @(negedge clk) begin
    // a closed command withdraws any offer left standing
    if (!dout_valid || took || !go) begin
      dout_valid = go && sent < count && !(stall && took);
      dout_data = dout_valid ? (sent[7:0] ^ 8'h5a) : ~dout_data;
    end
    din_ready = !stall || !din_ready; // slow sink toggles when stalling
  end
endmodule
`default_nettype wire

// >>> testbench/test_scsi_defect_list_and_buffer_write.sv
// self-checking bench for the defect list and buffer write handler
// assumes dlw_core, dlw_host and the bound checker are compiled
`include "dlw_map.svh"
`timescale 1ns/10ps
`default_nettype none
module test_scsi_defect_list_and_buffer_write;
  logic clk = 1'b0, rst = 1'b1, cdb_valid = 1'b0, go = 1'b0, stall = 1'b0;
  dlw_pkg::dlw_cdb_type cdb = '0; // command under test
  logic [2:0] issuer_id = 3'h5; // issuing initiator
  logic [13:0] nf = 14'h3, ng = 14'h2, di; // list sizes, lookup index
  logic dg, dv, dr, dov, dor, cr, nvc, uap, cd;
  logic [7:0] dd, dod, uam, umask;
  logic [23:0] cnt; // data-out length
  dlw_pkg::dlw_defect_type de;
  dlw_pkg::dlw_bufwr_type bw, wq[$];
  dlw_pkg::dlw_status_type st;
  int errors = 0, num_checks = 0, cyc = 0, ncommit, nua;
  // defect store: a made-up location per entry
  function automatic dlw_pkg::dlw_defect_type ent(logic g, logic [13:0] i);
    ent.cyl = {9'h0, g, i};
    ent.head = i[7:0] ^ 8'h33;
    ent.sector = {18'h0, i} + 32'h11;
    ent.bytes_ofs = {g, 17'h1, i};
  endfunction
  assign de = ent(dg, di);
  dlw_core #(.SEG_CAP(24'h000100)) dut (.clk(clk), .rst(rst), .cdb_valid(cdb_valid),
    .cdb(cdb), .issuer_id(issuer_id), .cdb_ready(cr), .factory_count(nf),
    .grown_count(ng), .desc_index(di), .desc_grown(dg), .desc_entry(de),
    .din_valid(dv), .din_data(dd), .din_ready(dr), .dout_valid(dov), .dout_data(dod),
    .dout_ready(dor), .dout_phase(), .buf_wr(bw), .nv_commit(nvc), .ua_post(uap),
    .ua_mask(uam), .ua_asc(), .cmd_done(cd), .status(st));
  dlw_host host (.clk(clk), .rst(rst), .go(go), .stall(stall), .count(cnt),
    .dout_valid(dov), .dout_data(dod), .dout_ready(dor), .din_valid(dv),
    .din_data(dd), .din_ready(dr));
  always #10 clk = ~clk;
  // gather stores and events; cut a hang short
  always @(negedge clk) begin
    cyc++;
    if (bw.we) wq.push_back(bw);
    if (nvc) ncommit++;
    if (uap) begin
      nua++;
      umask = uam;
    end
    if (cyc == 90000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk_num(logic [47:0] got, logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_wr(dlw_pkg::dlw_bufwr_type got, dlw_pkg::dlw_bufwr_type exp);
    chk_num(48'(got), 48'(exp));
  endtask
  task automatic chk_st(dlw_pkg::dlw_status_type got, dlw_pkg::dlw_status_type exp);
    chk_num(48'(got), 48'(exp));
  endtask
  // offer one command, then wait for its completion
  task automatic run(dlw_pkg::dlw_cdb_type c);
    @(negedge clk);
    cdb = c;
    cdb_valid = 1'b1;
    go = 1'b1;
    wq.delete();
    host.rx.delete();
    ncommit = 0;
    nua = 0;
    while (!cr) @(negedge clk);
    @(negedge clk);
    cdb_valid = 1'b0;
    while (!cd) @(negedge clk);
    go = 1'b0;
    @(negedge clk);
  endtask
  task automatic defect(logic f, logic g, logic [2:0] fmt, logic [15:0] al,
                        dlw_pkg::dlw_status_type es);
    dlw_pkg::dlw_cdb_type c;
    dlw_pkg::dlw_defect_type e;
    logic [2:0] fu;
    logic [15:0] ln, tot;
    logic [63:0] w;
    int n, d;
    fu = (fmt == 3'b100) ? fmt : 3'b101;
    n = (f ? nf : 0) + (g ? ng : 0);
    ln = 16'(8 * n);
    tot = (al < ln + 16'h4) ? al : ln + 16'h4;
    c = '0;
    c[0] = 8'h37;
    c[2] = {3'h0, f, g, fmt};
    {c[7], c[8]} = al;
    run(c);
    chk_num(48'(host.rx.size()), 48'(tot));
    chk_st(st, es);
    for (int k = 0; k < int'(tot); k++) begin
      if (k < 4) begin
        w = {8'h00, 3'h0, f, g, fu, ln, 32'h0};
      end else begin
        d = (k - 4) / 8;
        e = (f && d < nf) ? ent(1'b0, 14'(d)) : ent(1'b1, 14'(d - (f ? nf : 0)));
        w = {e.cyl, e.head, (fu == 3'b101) ? e.sector : e.bytes_ofs};
        w = w << (8 * ((k - 4) % 8));
      end
      if (k < 4) w = w << (8 * k);
      chk_num(48'(host.rx[k]), 48'(w[63:56]));
    end
  endtask
  task automatic wbuf(logic [2:0] m, logic [7:0] id, logic [23:0] ofs,
                      logic [23:0] len, logic ok);
    dlw_pkg::dlw_cdb_type c;
    dlw_pkg::dlw_bufwr_type e;
    int n;
    c = '0;
    c[0] = 8'h3b;
    c[1] = {5'h0, m};
    c[2] = id;
    {c[3], c[4], c[5]} = ofs;
    {c[6], c[7], c[8]} = len;
    cnt = len;
    run(c);
    n = !ok ? 0 : (m == 3'b000) ? int'(len) - 4 : int'(len);
    chk_num(48'(wq.size()), 48'(n));
    chk_st(st, ok ? 13'h0 : {1'b1, `DLW_SK_ILLEGAL, `DLW_ASC_INV_FIELD});
    chk_num(48'(ncommit), 48'(ok && m == 3'b101));
    for (int k = 0; k < n && k < wq.size(); k++) begin
      e.we = 1'b1;
      e.code = (m == 3'b101);
      e.seg = (m == 3'b010) ? id : 8'h00;
      e.addr = (m == 3'b010) ? ofs + 24'(k) : 24'(k);
      e.data = 8'((m == 3'b000) ? k + 4 : k) ^ 8'h5a;
      chk_wr(wq[k], e);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    stall = 1'b1;
    defect(1'b1, 1'b1, 3'b101, 16'h00ff, 13'h0);
    defect(1'b0, 1'b1, 3'b100, 16'h00ff, 13'h0);
    defect(1'b1, 1'b0, 3'b110, 16'h00ff, {1'b1, `DLW_SK_RECOVERED, `DLW_ASC_FMT_NA});
    defect(1'b1, 1'b1, 3'b100, 16'h000a, 13'h0);
    defect(1'b0, 1'b0, 3'b101, 16'h00ff, 13'h0);
    defect(1'b1, 1'b1, 3'b101, 16'h0000, 13'h0);
    wbuf(3'b000, 8'h00, 24'h0, 24'h00000c, 1'b1);
    wbuf(3'b010, 8'h02, 24'h0000f0, 24'h000010, 1'b1);
    wbuf(3'b010, 8'h02, 24'h0000f0, 24'h000012, 1'b0);
    wbuf(3'b000, 8'h00, 24'h0, 24'h060005, 1'b0);
    wbuf(3'b000, 8'h00, 24'h0, 24'h000104, 1'b1);
    for (int m = 0; m < 8; m++) begin
      if (m != 0 && m != 2 && m != 5) wbuf(3'(m), 8'h00, 24'h0, 24'h000008, 1'b0);
    end
    stall = 1'b0;
    wbuf(3'b101, 8'h77, 24'h000123, 24'h00c000, 1'b1);
    chk_num(48'(nua), 48'h1);
    chk_num(48'(umask), 48'(8'(~(8'h01 << issuer_id))));
    tally_and_finish();
  end
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
